/* File: logic/dtm_timer.sv */
// two-channel 16-bit compare timer with four pwm outputs
//
// Notes on behaviour
// R1 - shared mode lets any block pick counter
// R2 - shared mode clocks all counters from ch0
// R3 - half clock: dual-edge counter drives compare A
// R4 - normal clock: main counter drives compare A
// R5 - software uses half clock only when legal
// R6 - dual-edge counter is never readable
// R7 - software ignores compare A irq in half clock
// R8 - software keeps compare B below A/2+0x8000
// R9 - writing reset bit clears counter
// R10 - counter clears itself at compare B
// R11 - run bit starts, clear stops counting
// R12 - start/stop never alters counter value
// R13 - run plus reset clears then counts
// R14 - whole counter read in one access
// R15 - software configures before starting count
// R16 - two outputs per channel from compares
// R17 - output A and B configured independently
// R18 - mode 3 B-toggle, 2 A-toggle, 1 set/clear
// R19 - mode 0 disables the output
// R20 - invert bit makes output active low
// R21 - counter clear forces outputs inactive
// R22 - counter select 0/1, reserved codes use 0
// R23 - compare B match sets compare B flag
// R24 - outputs update on the compare edge
`timescale 1ns/100ps
`default_nettype none
module dtm_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire logic [dtm_pkg::DTM_AW-1:0] bus_addr,
  input wire logic [dtm_pkg::DTM_DW-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [dtm_pkg::DTM_DW-1:0] bus_rdata,
  // timer output pins
  output logic output_a_pin_ch0,
  output logic output_b_pin_ch0,
  output logic output_a_pin_ch1,
  output logic output_b_pin_ch1
);
  import dtm_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [1:0] run_r;
  logic [1:0] hcm_r;
  logic [1:0] sel_r [2];
  logic [15:0] cca_r [2];
  logic [15:0] ccb_r [2];
  dtm_outcfg_t cfga_r [2];
  dtm_outcfg_t cfgb_r [2];
  logic [DTM_DIVW-1:0] div_r [2];
  logic shared_r;
  logic [1:0] fla_r;
  logic [1:0] flb_r;
  logic [15:0] cnt_r [2];
  logic [16:0] dual_r [2];
  logic [DTM_DIVW-1:0] pre_r [2];
  logic [1:0] phase_r;
  logic [15:0] rd_nxt;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  function automatic logic hit(input logic [4:0] a, input logic [4:0] reg_i,
                               input logic ch);
    hit = (a == (ch ? (reg_i + DTM_CH_STRIDE) : reg_i));
  endfunction

  // reserved select codes fall back to counter 0
  function automatic logic src_of(input logic shr, input logic [1:0] sel,
                                  input logic own);
    src_of = shr ? (sel == DTM_SEL_C1) : own;  // see R1, R22
  endfunction

  logic [1:0] wr_ctl;
  logic [1:0] wr_cca;
  logic [1:0] wr_ccb;
  logic [1:0] wr_ccctl;
  logic wr_clk;
  logic [1:0] swrst;
  logic [1:0] half_tick;
  logic [1:0] tick;
  logic [1:0] wrap;
  logic [1:0] src;
  logic [1:0] cmp_a;
  logic [1:0] cmp_b;
  logic [DTM_DIVW-1:0] div_eff [2];
  dtm_evt_t evt [2];

  assign wr_clk = bus_wr && (bus_addr == DTM_CLK);

  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : g_dec
      assign wr_ctl[k] = bus_wr && hit(bus_addr, DTM_CTL, 1'(k));
      assign wr_cca[k] = bus_wr && hit(bus_addr, DTM_CCA, 1'(k));
      assign wr_ccb[k] = bus_wr && hit(bus_addr, DTM_CCB, 1'(k));
      assign wr_ccctl[k] = bus_wr && hit(bus_addr, DTM_CCCTL, 1'(k));
      assign swrst[k] = wr_ctl[k] && bus_wdata[DTM_RST_B];  // see R9
      // count clock: one half tick per (div+1) system cycles
      assign div_eff[k] = shared_r ? div_r[0] : div_r[k];  // see R2
      assign half_tick[k] = run_r[k] && (pre_r[k] == div_eff[k]);
      assign tick[k] = half_tick[k] && phase_r[k];
      assign src[k] = src_of(shared_r, sel_r[k], 1'(k));
    end
  endgenerate

  // a counter wraps when any block fed by it matches compare B
  generate
    for (k = 0; k < 2; k++) begin : g_wrap
      assign wrap[k] = ((src[0] == 1'(k)) && (cnt_r[k] == ccb_r[0]))
                    || ((src[1] == 1'(k)) && (cnt_r[k] == ccb_r[1]));
    end
  endgenerate

  // ------------------------------------------------------------
  // counters
  // ------------------------------------------------------------
  generate
    for (k = 0; k < 2; k++) begin : g_cnt
      logic [15:0] cnt_nxt;
      logic [16:0] dual_nxt;
      logic [DTM_DIVW-1:0] pre_nxt;
      // reset wins over everything; stopped counters hold
      assign cnt_nxt = swrst[k] ? DTM_ZERO16 :  // see R9, R13
        (tick[k] ? (wrap[k] ? DTM_ZERO16 : cnt_r[k] + 16'h0001)  // see R10
                 : cnt_r[k]);  // see R12
      assign dual_nxt = swrst[k] ? 17'h00000 :
        (half_tick[k] ? ((tick[k] && wrap[k]) ? 17'h00000
                         : dual_r[k] + 17'h00001)  // see R3
                      : dual_r[k]);
      assign pre_nxt = (swrst[k] || half_tick[k] || !run_r[k])
                     ? pre_r[k] & {DTM_DIVW{1'b0}}
                     : pre_r[k] + {{(DTM_DIVW-1){1'b0}}, 1'b1};
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          cnt_r[k] <= 16'h0000;
          dual_r[k] <= 17'h00000;
          pre_r[k] <= {DTM_DIVW{1'b0}};
          phase_r[k] <= 1'b0;
        end else begin
          cnt_r[k] <= cnt_nxt;
          dual_r[k] <= dual_nxt;
          pre_r[k] <= pre_nxt;
          phase_r[k] <= swrst[k] ? 1'b0 : (phase_r[k] ^ half_tick[k]);
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // comparator blocks and outputs
  // ------------------------------------------------------------
  logic [1:0] pin_a;
  logic [1:0] pin_b;

  generate
    for (k = 0; k < 2; k++) begin : g_cmp
      // half clock doubles duty resolution on compare A only
      assign cmp_a[k] = hcm_r[k]
        ? (half_tick[src[k]] && (dual_r[src[k]] == {1'b0, cca_r[k]}))
        : (tick[src[k]] && (cnt_r[src[k]] == cca_r[k]));  // see R3, R4
      assign cmp_b[k] = tick[src[k]]
        && (cnt_r[src[k]] == ccb_r[k]);  // see R23
      assign evt[k] = '{cmp_a: cmp_a[k], cmp_b: cmp_b[k],
                        clr: swrst[src[k]]};
      // two independent generators per channel
      dtm_out_gen u_gen_a (  // see R16, R17
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .cfg(cfga_r[k]),
        .evt(evt[k]),
        .pin_out(pin_a[k])
      );
      dtm_out_gen u_gen_b (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .cfg(cfgb_r[k]),
        .evt(evt[k]),
        .pin_out(pin_b[k])
      );
    end
  endgenerate

  assign output_a_pin_ch0 = pin_a[0];
  assign output_b_pin_ch0 = pin_b[0];
  assign output_a_pin_ch1 = pin_a[1];
  assign output_b_pin_ch1 = pin_b[1];

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  generate
    for (k = 0; k < 2; k++) begin : g_regs
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          run_r[k] <= 1'b0;
          hcm_r[k] <= 1'b0;
          sel_r[k] <= 2'h0;
          cca_r[k] <= 16'h0000;
          ccb_r[k] <= 16'h0000;
          cfga_r[k] <= '{mode: DTM_CCCTL_RST, inv: 1'b0};
          cfgb_r[k] <= '{mode: DTM_CCCTL_RST, inv: 1'b0};
          div_r[k] <= {DTM_DIVW{1'b0}};
          fla_r[k] <= 1'b0;
          flb_r[k] <= 1'b0;
        end else begin
          if (wr_ctl[k]) begin
            run_r[k] <= bus_wdata[DTM_RUN_B];  // see R11
            hcm_r[k] <= bus_wdata[DTM_HCM_B];
            sel_r[k] <= bus_wdata[DTM_SEL_L +: 2];
          end
          if (wr_cca[k]) begin
            cca_r[k] <= bus_wdata;
          end
          if (wr_ccb[k]) begin
            ccb_r[k] <= bus_wdata;
          end
          if (wr_ccctl[k]) begin
            cfga_r[k] <= '{mode: bus_wdata[DTM_MDA_L +: 2],
                           inv: bus_wdata[DTM_INVA_B]};
            cfgb_r[k] <= '{mode: bus_wdata[DTM_MDB_L +: 2],
                           inv: bus_wdata[DTM_INVB_B]};
          end
          if (wr_clk) begin
            div_r[k] <= k ? bus_wdata[DTM_DIV1_L +: DTM_DIVW]
                          : bus_wdata[DTM_DIV0_L +: DTM_DIVW];
          end
          // write-one-to-clear, a new match on the same edge wins
          fla_r[k] <= cmp_a[k] ||
            (fla_r[k] && !(wr_ctl[k] && bus_wdata[DTM_FLA_B]));
          flb_r[k] <= cmp_b[k] ||
            (flb_r[k] && !(wr_ctl[k] && bus_wdata[DTM_FLB_B]));  // see R23
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_comb begin
    rd_nxt = 16'h0000;
    for (int c = 0; c < 2; c++) begin
      if (hit(bus_addr, DTM_CTL, c[0])) begin
        rd_nxt = {6'h00, flb_r[c], fla_r[c], 2'h0, sel_r[c], hcm_r[c],
                  2'h0, run_r[c]};
      end
      if (hit(bus_addr, DTM_TC, c[0])) begin
        rd_nxt = cnt_r[c];  // see R14, R6
      end
      if (hit(bus_addr, DTM_CCA, c[0])) begin
        rd_nxt = cca_r[c];
      end
      if (hit(bus_addr, DTM_CCB, c[0])) begin
        rd_nxt = ccb_r[c];
      end
      if (hit(bus_addr, DTM_CCCTL, c[0])) begin
        rd_nxt = {9'h000, cfgb_r[c].inv, cfgb_r[c].mode, 1'b0,
                  cfga_r[c].inv, cfga_r[c].mode};
      end
    end
    if (bus_addr == DTM_CLK) begin
      rd_nxt = {7'h00, shared_r, div_r[1], div_r[0]};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_rdata <= 16'h0000;
      shared_r <= 1'b0;
    end else begin
      bus_rdata <= bus_rd ? rd_nxt : 16'h0000;
      if (wr_clk) begin
        shared_r <= bus_wdata[DTM_SHR_B];
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_reset_clears: assert property (swrst[0] |=> cnt_r[0] == 16'h0000 // see R9
    && dual_r[0] == 17'h00000) else $error("reset write left count");
  a_stop_holds: assert property (!run_r[0] && !swrst[0] // see R12
    |=> $stable(cnt_r[0])) else $error("stopped counter moved");
  a_wrap_zero: assert property (tick[0] && wrap[0] && !swrst[0] // see R10
    |=> cnt_r[0] == 16'h0000) else $error("no wrap at compare b");
  a_dual_track: assert property (dual_r[0] == {cnt_r[0], phase_r[0]}) // see R3
    else $error("dual counter out of step");
  a_shared_clock: assert property (shared_r && half_tick[1] // see R2
    |-> pre_r[1] == div_r[0]) else $error("shared clock not ch0");
  a_rise_on_a: assert property (cmp_a[0] && !cmp_b[0] && !evt[0].clr // see R18
    && cfga_r[0].mode == DTM_OM_AB |=> output_a_pin_ch0 == ~$past(cfga_r[0].inv))
    else $error("output a not active after compare a");
  a_off_inactive: assert property (cfgb_r[1].mode == DTM_OM_OFF // see R19
    |=> output_b_pin_ch1 == $past(cfgb_r[1].inv))
    else $error("disabled output not inactive");
  a_clr_inactive: assert property (evt[0].clr // see R21
    |=> output_b_pin_ch0 == $past(cfgb_r[0].inv))
    else $error("clear left output active");
  a_read_count: assert property (bus_rd && bus_addr == DTM_TC // see R14
    |=> bus_rdata == $past(cnt_r[0]) ##1 bus_rdata == 16'h0000 || $past(bus_rd))
    else $error("counter read wrong");
  a_flag_set: assert property (cmp_b[1] |=> flb_r[1]) // see R23
    else $error("compare b flag missed");

  c_wrap: cover property (tick[0] && wrap[0]);
  c_half_cmp: cover property (hcm_r[0] && cmp_a[0] && !tick[0]);
  c_shared: cover property (shared_r && src[1] == 1'b0 && cmp_b[1]);
  c_toggle: cover property (cfga_r[1].mode == DTM_OM_TGB && cmp_b[1]);
endmodule
`default_nettype wire

/* File: logic/dtm_pkg.sv */
// shared constants, types and the timer output generator
`timescale 1ns/100ps
`default_nettype none
package dtm_pkg;
  localparam int DTM_AW = 5;
  localparam int DTM_DW = 16;
  localparam int DTM_DIVW = 4;
  // register word indices, channel 1 sits at CH_STRIDE above channel 0
  localparam logic [4:0] DTM_CTL = 5'h00;
  localparam logic [4:0] DTM_TC = 5'h01;
  localparam logic [4:0] DTM_CCA = 5'h02;
  localparam logic [4:0] DTM_CCB = 5'h03;
  localparam logic [4:0] DTM_CCCTL = 5'h04;
  localparam logic [4:0] DTM_CH_STRIDE = 5'h08;
  localparam logic [4:0] DTM_CLK = 5'h10;
  // channel control fields
  localparam int DTM_RUN_B = 0;
  localparam int DTM_RST_B = 1;
  localparam int DTM_HCM_B = 3;
  localparam int DTM_SEL_L = 4;
  localparam int DTM_FLA_B = 8;
  localparam int DTM_FLB_B = 9;
  // compare/capture control fields
  localparam int DTM_MDA_L = 0;
  localparam int DTM_INVA_B = 2;
  localparam int DTM_MDB_L = 4;
  localparam int DTM_INVB_B = 6;
  // clock control fields
  localparam int DTM_DIV0_L = 0;
  localparam int DTM_DIV1_L = 4;
  localparam int DTM_SHR_B = 8;
  // output generation modes
  localparam logic [1:0] DTM_OM_OFF = 2'h0;
  localparam logic [1:0] DTM_OM_AB = 2'h1;
  localparam logic [1:0] DTM_OM_TGA = 2'h2;
  localparam logic [1:0] DTM_OM_TGB = 2'h3;
  localparam logic [1:0] DTM_SEL_C1 = 2'h1;
  localparam logic [15:0] DTM_ZERO16 = 16'h0000;
  localparam logic [1:0] DTM_CCCTL_RST = 2'h0;

  typedef struct packed {
    logic [1:0] mode;
    logic inv;
  } dtm_outcfg_t;

  typedef struct packed {
    logic cmp_a;
    logic cmp_b;
    logic clr;
  } dtm_evt_t;
endpackage

module dtm_out_gen (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // configuration and events
  input wire dtm_pkg::dtm_outcfg_t cfg,
  input wire dtm_pkg::dtm_evt_t evt,
  // pin level
  output logic pin_out
);
  import dtm_pkg::*;
  logic act_r;
  logic act_nxt;
  logic pin_nxt;

  // clear beats any compare event on the same edge
  always_comb begin
    act_nxt = act_r;
    if (evt.clr) begin
      act_nxt = 1'b0;  // see R21
    end else begin
      case (cfg.mode)  // see R18
        DTM_OM_AB: begin
          if (evt.cmp_b) begin
            act_nxt = 1'b0;
          end else if (evt.cmp_a) begin
            act_nxt = 1'b1;
          end
        end
        DTM_OM_TGA: act_nxt = evt.cmp_a ? ~act_r : act_r;
        DTM_OM_TGB: act_nxt = evt.cmp_b ? ~act_r : act_r;
        default: act_nxt = 1'b0;  // see R19
      endcase
    end
  end
  assign pin_nxt = act_nxt ^ cfg.inv;  // see R20

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      act_r <= 1'b0;
      pin_out <= 1'b0;
    end else begin
      act_r <= act_nxt;  // see R24
      pin_out <= pin_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: bench/dtm_pin_mon.sv */
// model of the external loads on the four timer output pins
`timescale 1ns/100ps
`default_nettype none
module dtm_pin_mon (
  // clock and window control
  input wire logic clk_sys,
  input wire logic clr,
  // observed pin levels
  input wire logic [3:0] pin_lvl,
  // per-pin rising edge and high-cycle counts
  output logic [3:0][15:0] rises_r,
  output logic [3:0][15:0] highs_r
);
  logic [3:0] last_r;

  // counts only, no drive back: the loads are passive inputs
  always_ff @(posedge clk_sys) begin
    last_r <= pin_lvl;
    for (int i = 0; i < 4; i++) begin
      if (clr) begin
        rises_r[i] <= 16'h0000;
        highs_r[i] <= 16'h0000;
      end else begin
        rises_r[i] <= rises_r[i] + {15'h0000, pin_lvl[i] & ~last_r[i]};
        highs_r[i] <= highs_r[i] + {15'h0000, pin_lvl[i]};
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb_dtm_timer.sv */
// self-checking testbench for the two-channel compare timer
`timescale 1ns/100ps
`default_nettype none
module tb_dtm_timer;
  import dtm_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [DTM_AW-1:0] bus_addr = 5'h00;
  logic [DTM_DW-1:0] bus_wdata = 16'h0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [DTM_DW-1:0] bus_rdata;
  logic mon_clr = 1'b1;
  wire [3:0] pins;
  logic [3:0][15:0] rises;
  logic [3:0][15:0] highs;
  int err_count = 0;
  int tests_run = 0;
  localparam logic [4:0] CH1 = DTM_CH_STRIDE;

  always #5 clk_sys = ~clk_sys;

  dtm_timer i_dtm_timer (.clk_sys(clk_sys), .rst_b(rst_b),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .output_a_pin_ch0(pins[0]), .output_b_pin_ch0(pins[1]),
    .output_a_pin_ch1(pins[2]), .output_b_pin_ch1(pins[3]));

  dtm_pin_mon i_dtm_pin_mon (.clk_sys(clk_sys), .clr(mon_clr),
    .pin_lvl(pins), .rises_r(rises), .highs_r(highs));

  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] near(input logic [15:0] x, input int e);
    // edge counts over a window may be off by one at its ends
    if (e == 0) return {15'h0000, x == 16'h0000};
    return {15'h0000, (int'(x) >= e - 1) && (int'(x) <= e + 1)};
  endfunction

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask

  task automatic measure(input int n);
    @(posedge clk_sys);
    mon_clr <= 1'b1;
    @(posedge clk_sys);
    mon_clr <= 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_vals;
    logic [15:0] v;
    rd(DTM_CCCTL, v);
    chk(v, 16'h0000);
    rd(DTM_CLK, v);
    chk(v, 16'h0000);
    rd(5'h1f, v);
    chk(v, 16'h0000);
    chk({12'h000, pins}, 16'h0000);
    $display("test reset_vals done");
  endtask

  task automatic t_modes;
    logic [1:0] ma [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1};
    logic [1:0] mb [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    int ea;
    int eb;
    wr(DTM_CLK, 16'h0000);
    wr(DTM_CCA, 16'h0001);
    wr(DTM_CCB, 16'h0002);
    for (int k = 0; k < 5; k++) begin
      // period is three counts of two cycles: six cycles
      ea = (ma[k] == 2'h0) ? 0 : (ma[k] == 2'h1) ? 10 : 5;
      eb = (mb[k] == 2'h0) ? 0 : (mb[k] == 2'h1) ? 10 : 5;
      wr(DTM_CCCTL, {9'h000, 1'b0, mb[k], 2'h0, ma[k]});
      wr(DTM_CTL, 16'h0003);
      measure(60);
      chk(near(rises[0], ea), 16'h0001);
      chk(near(rises[1], eb), 16'h0001);
    end
    $display("test modes done");
  endtask

  task automatic t_half_clock;
    logic [15:0] hn;
    logic [15:0] v;
    wr(DTM_CCCTL, 16'h0001);
    wr(DTM_CTL, 16'h0003);
    measure(60);
    hn = highs[0];
    chk(near(hn, 20), 16'h0001);
    wr(DTM_CTL, 16'h000b);
    measure(60);
    chk({15'h0000, highs[0] > hn}, 16'h0001);
    // dual-edge match at half count 1 of 6: high four cycles in six
    chk(near(highs[0], 40), 16'h0001);
    rd(DTM_TC, v);
    chk({15'h0000, v <= 16'h0002}, 16'h0001);
    $display("test half_clock done");
  endtask

  task automatic t_inv_clear;
    wr(DTM_CCCTL, 16'h0004);
    @(posedge clk_sys);
    #1 chk({15'h0000, pins[0]}, 16'h0001);
    wr(DTM_CCCTL, 16'h0005);
    wr(DTM_CTL, 16'h0003);
    measure(30);
    chk(near(rises[0], 5), 16'h0001);
    wr(DTM_CTL, 16'h0002);
    @(posedge clk_sys);
    #1 chk({15'h0000, pins[0]}, 16'h0001);
    $display("test inv_clear done");
  endtask

  task automatic t_stop_hold;
    logic [15:0] v1;
    logic [15:0] v2;
    wr(DTM_CCCTL, 16'h0000);
    wr(DTM_CCA, 16'hfffe);
    wr(DTM_CCB, 16'hffff);
    wr(DTM_CTL, 16'h0003);
    repeat (20) @(posedge clk_sys);
    wr(DTM_CTL, 16'h0000);
    rd(DTM_TC, v1);
    repeat (10) @(posedge clk_sys);
    rd(DTM_TC, v2);
    chk(v2, v1);
    chk({15'h0000, v1 >= 16'h0008}, 16'h0001);
    wr(DTM_CTL, 16'h0001);
    repeat (10) @(posedge clk_sys);
    rd(DTM_TC, v2);
    chk({15'h0000, v2 > v1}, 16'h0001);
    wr(DTM_CTL, 16'h0002);
    rd(DTM_TC, v2);
    chk(v2, 16'h0000);
    $display("test stop_hold done");
  endtask

  task automatic t_shared;
    logic [15:0] v;
    // ch1 divider is slow, shared mode must ignore it
    wr(DTM_CLK, 16'h01f0);
    wr(CH1 + DTM_CCA, 16'hfffe);
    wr(CH1 + DTM_CCB, 16'hffff);
    wr(CH1 + DTM_CTL, 16'h0003);
    repeat (40) @(posedge clk_sys);
    wr(CH1 + DTM_CTL, 16'h0000);
    rd(CH1 + DTM_TC, v);
    chk({15'h0000, v >= 16'h000f}, 16'h0001);
    wr(DTM_CCA, 16'h0001);
    wr(DTM_CCB, 16'h0002);
    wr(DTM_CCCTL, 16'h0001);
    // ch1 block joins counter 1 too, output a toggles on compare b
    wr(CH1 + DTM_CCA, 16'h0000);
    wr(CH1 + DTM_CCB, 16'h0002);
    wr(CH1 + DTM_CCCTL, 16'h0013);
    wr(DTM_CTL, 16'h0010);
    wr(CH1 + DTM_CTL, 16'h0013);
    measure(60);
    chk(near(rises[0], 10), 16'h0001);
    chk(near(rises[2], 5), 16'h0001);
    chk(near(rises[3], 10), 16'h0001);
    rd(CH1 + DTM_CTL, v);
    chk(v, 16'h0311);
    $display("test shared done");
  endtask

  task automatic summarize;
    $display("counts: run=%0d bad=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #300us;
    err_count++;
    summarize();
  end

  // software order: configure outputs and compares before starting
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset_vals();
    t_modes();
    t_half_clock();
    t_inv_clear();
    t_stop_hold();
    t_shared();
    summarize();
  end
endmodule
`default_nettype wire
